// >>> core/external_memory_port_cfg.svh
// Constants for the external data memory interface
`ifndef EXTERNAL_MEMORY_PORT_CFG_SVH
`define EXTERNAL_MEMORY_PORT_CFG_SVH

// Interface mode field codes
`define MODE_INTERNAL 2'h0
`define MODE_SPLIT_NOBANK 2'h1
`define MODE_SPLIT_BANK 2'h2
`define MODE_EXTERNAL 2'h3

// On-chip memory geometry and data pointer width
`define RAM_ADDR_W 12
`define RAM_DATA_W 8
`define PTR_W 16

// Page register fields
`define PAGE_MSB 4
`define PAGE_OFFCHIP_BIT 4
`define PAGE_BANK_MSB 3

// Configuration register fields
`define CFG_MODE_MSB 3
`define CFG_MODE_LSB 2
`define CFG_ALE_MSB 1
`define CFG_ALE_LSB 0

// Timing register fields
`define TIM_SETUP_MSB 7
`define TIM_SETUP_LSB 6
`define TIM_STROBE_MSB 5
`define TIM_STROBE_LSB 2
`define TIM_HOLD_MSB 1
`define TIM_HOLD_LSB 0

// Reset values
`define PAGE_RESET 5'h00
`define MODE_RESET 2'h0
`define ALE_RESET 2'h3
`define SETUP_RESET 2'h3
`define STROBE_RESET 4'hF
`define HOLD_RESET 2'h3

// Fixed cycles added to every off-chip access
`define ACCESS_OVERHEAD 7'h04

// Control pin positions
`define CTL_ALE 2
`define CTL_WR 1
`define CTL_RD 0

`endif

// >>> core/external_memory_port_pkg.sv
// Types shared by the external data memory interface
`include "external_memory_port_cfg.svh"

package external_memory_port_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ONCHIP, ST_ADDR, ST_ALE_HI, ST_ALE_LO, ST_SETUP,
        ST_STROBE, ST_HOLD, ST_END, ST_FINISH, ST_RESULT
    } state_e;

    typedef struct packed {
        logic is_16bit;
        logic write;
        logic [7:0] index;
        logic [`PTR_W-1:0] data_pointer_register;
        logic [7:0] wdata;
    } move_req_s;

    typedef struct packed {
        logic [7:0] ad;
        logic [7:0] alo;
        logic [3:0] ahi;
        logic [2:0] ctl;
    } pin_vals_s;

    typedef struct packed {
        state_e state;
        logic [3:0] cnt;
        logic [`PAGE_MSB:0] page;
        logic [1:0] mode;
        logic [1:0] ale_w;
        logic [1:0] eas;
        logic [3:0] ewr;
        logic [1:0] eah;
        logic is16;
        logic write;
        logic offchip;
        logic [`RAM_ADDR_W-1:0] addr;
        logic drive_hi;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic done;
        logic busy;
        logic [7:0] sync1;
        logic [7:0] sync2;
        pin_vals_s claim;
        pin_vals_s pin_out;
        pin_vals_s pin_oe_n;
    } external_memory_port_state_s;

endpackage

// >>> core/on_chip_external_ram_store.sv
// On-chip external data RAM with registered read data
`timescale 1ns/1ns

module on_chip_external_ram_store #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 12
) (
    // Clock
    input wire logic clk,
    // Access port
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);

    logic [DATA_W-1:0] mem [2**ADDR_W];

    // Write port and registered read
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule

// >>> core/external_memory_port_core.sv
// External data memory interface: mapping, pin sequencing and on-chip RAM
`timescale 1ns/1ns
`include "external_memory_port_cfg.svh"

module external_memory_port_core (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Configuration writes
    input wire logic page_we,
    input wire logic config_we,
    input wire logic timing_we,
    input wire logic [7:0] reg_wdata,
    input wire logic mux_mode,
    // External move from the core
    input wire logic move_valid,
    input wire external_memory_port_pkg::move_req_s move_req,
    output logic move_done,
    output logic [7:0] move_rdata,
    output logic busy,
    // Port pins and their latches
    input wire logic [7:0] ad_in,
    input wire external_memory_port_pkg::pin_vals_s port_latch,
    input wire external_memory_port_pkg::pin_vals_s port_pushpull,
    output external_memory_port_pkg::pin_vals_s pin_out,
    output external_memory_port_pkg::pin_vals_s pin_oe_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Off-chip decision for a move under the current mode
    function automatic logic goes_offchip(input logic [1:0] mode, input logic is16,
                                          input logic [`PAGE_MSB:0] page,
                                          input logic [`PTR_W-1:0] data_pointer_register);
        case (mode)
            `MODE_INTERNAL: goes_offchip = 1'b0;
            `MODE_SPLIT_NOBANK, `MODE_SPLIT_BANK: begin
                goes_offchip = is16 ? (|data_pointer_register[`PTR_W-1:`RAM_ADDR_W]) : page[`PAGE_OFFCHIP_BIT];
            end
            default: goes_offchip = 1'b1;
        endcase
    endfunction

    // Driver enable from value and output mode; open-drain drives only lows
    function automatic external_memory_port_pkg::pin_vals_s drive_enable_n(input external_memory_port_pkg::pin_vals_s val,
                                                            input external_memory_port_pkg::pin_vals_s pp);
        drive_enable_n = ~pp & val;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State and memory

    external_memory_port_pkg::external_memory_port_state_s s_reg;
    external_memory_port_pkg::external_memory_port_state_s s_next;
    logic mem_we;
    logic [7:0] mem_rdata;
    logic go_setup;
    logic active;
    logic data_phase;
    external_memory_port_pkg::pin_vals_s claim;
    external_memory_port_pkg::pin_vals_s external_memory_port_val;
    external_memory_port_pkg::pin_vals_s in_mask;
    external_memory_port_pkg::pin_vals_s merged;

    // On-chip RAM write strobe
    assign mem_we = (s_reg.state == external_memory_port_pkg::ST_ONCHIP) && s_reg.write;

    on_chip_external_ram_store #(
        .DATA_W(`RAM_DATA_W),
        .ADDR_W(`RAM_ADDR_W)
    ) u_ram (
        .clk(clk),
        .we(mem_we),
        .addr(s_reg.addr),
        .wdata(s_reg.wdata),
        .rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        go_setup = 1'b0;
        // Two-stage synchroniser on the data pins; the first stage samples only while the
        // read strobe pin is low, so the last strobe cycle survives any programmed hold time
        s_next.sync1 = s_reg.pin_out.ctl[`CTL_RD] ? s_reg.sync1 : ad_in;
        s_next.sync2 = s_reg.sync1;
        // Configuration writes
        if (page_we) begin
            s_next.page = reg_wdata[`PAGE_MSB:0];
        end
        if (config_we) begin
            s_next.mode = reg_wdata[`CFG_MODE_MSB:`CFG_MODE_LSB];
            s_next.ale_w = reg_wdata[`CFG_ALE_MSB:`CFG_ALE_LSB];
        end
        if (timing_we) begin
            s_next.eas = reg_wdata[`TIM_SETUP_MSB:`TIM_SETUP_LSB];
            s_next.ewr = reg_wdata[`TIM_STROBE_MSB:`TIM_STROBE_LSB];
            s_next.eah = reg_wdata[`TIM_HOLD_MSB:`TIM_HOLD_LSB];
        end
        // Access sequencer
        case (s_reg.state)
            external_memory_port_pkg::ST_IDLE: begin
                if (move_valid) begin
                    s_next.is16 = move_req.is_16bit;
                    s_next.write = move_req.write;
                    s_next.wdata = move_req.wdata;
                    s_next.offchip = goes_offchip(s_reg.mode, move_req.is_16bit, s_reg.page, move_req.data_pointer_register);
                    if (move_req.is_16bit) begin
                        s_next.addr = move_req.data_pointer_register[`RAM_ADDR_W-1:0];
                    end else begin
                        s_next.addr = {s_reg.page[`PAGE_BANK_MSB:0], move_req.index};
                    end
                    s_next.drive_hi = move_req.is_16bit || (s_reg.mode == `MODE_SPLIT_BANK);
                    s_next.busy = 1'b1;
                    s_next.state = s_next.offchip ? external_memory_port_pkg::ST_ADDR : external_memory_port_pkg::ST_ONCHIP;
                end
            end
            external_memory_port_pkg::ST_ONCHIP: s_next.state = external_memory_port_pkg::ST_RESULT;
            external_memory_port_pkg::ST_ADDR: begin
                if (mux_mode) begin
                    s_next.state = external_memory_port_pkg::ST_ALE_HI;
                    s_next.cnt = {2'h0, s_reg.ale_w};
                end else begin
                    go_setup = 1'b1;
                end
            end
            external_memory_port_pkg::ST_ALE_HI: begin
                if (s_reg.cnt == 4'h0) begin
                    s_next.state = external_memory_port_pkg::ST_ALE_LO;
                    s_next.cnt = {2'h0, s_reg.ale_w};
                end else begin
                    s_next.cnt = s_reg.cnt - 4'h1;
                end
            end
            external_memory_port_pkg::ST_ALE_LO: begin
                if (s_reg.cnt == 4'h0) begin
                    go_setup = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt - 4'h1;
                end
            end
            external_memory_port_pkg::ST_SETUP: begin
                if (s_reg.cnt == 4'h0) begin
                    s_next.state = external_memory_port_pkg::ST_STROBE;
                    s_next.cnt = s_reg.ewr;
                end else begin
                    s_next.cnt = s_reg.cnt - 4'h1;
                end
            end
            external_memory_port_pkg::ST_STROBE: begin
                if (s_reg.cnt != 4'h0) begin
                    s_next.cnt = s_reg.cnt - 4'h1;
                end else if (s_reg.eah != 2'h0) begin
                    s_next.state = external_memory_port_pkg::ST_HOLD;
                    s_next.cnt = {2'h0, s_reg.eah} - 4'h1;
                end else begin
                    s_next.state = external_memory_port_pkg::ST_END;
                end
            end
            external_memory_port_pkg::ST_HOLD: begin
                if (s_reg.cnt == 4'h0) begin
                    s_next.state = external_memory_port_pkg::ST_END;
                end else begin
                    s_next.cnt = s_reg.cnt - 4'h1;
                end
            end
            external_memory_port_pkg::ST_END: s_next.state = external_memory_port_pkg::ST_FINISH;
            external_memory_port_pkg::ST_FINISH: s_next.state = external_memory_port_pkg::ST_RESULT;
            external_memory_port_pkg::ST_RESULT: begin
                if (!s_reg.write) begin
                    s_next.rdata = s_reg.offchip ? s_reg.sync2 : mem_rdata;
                end
                s_next.done = 1'b1;
                s_next.busy = 1'b0;
                s_next.state = external_memory_port_pkg::ST_IDLE;
            end
            default: s_next.state = external_memory_port_pkg::ST_IDLE;
        endcase
        // Setup entry, skipped when the setup time is zero
        if (go_setup) begin
            if (s_reg.eas != 2'h0) begin
                s_next.state = external_memory_port_pkg::ST_SETUP;
                s_next.cnt = {2'h0, s_reg.eas} - 4'h1;
            end else begin
                s_next.state = external_memory_port_pkg::ST_STROBE;
                s_next.cnt = s_reg.ewr;
            end
        end
        // Pin ownership and values for the current phase
        active = s_reg.offchip && (s_reg.state != external_memory_port_pkg::ST_IDLE) &&
                 (s_reg.state != external_memory_port_pkg::ST_ONCHIP) && (s_reg.state != external_memory_port_pkg::ST_RESULT);
        data_phase = (s_reg.state != external_memory_port_pkg::ST_ADDR) && (s_reg.state != external_memory_port_pkg::ST_ALE_HI) &&
                     (s_reg.state != external_memory_port_pkg::ST_ALE_LO);
        claim = '0;
        external_memory_port_val = '0;
        in_mask = '0;
        if (active) begin
            claim.ctl = '1;
            external_memory_port_val.ctl[`CTL_ALE] = (s_reg.state == external_memory_port_pkg::ST_ALE_HI);
            external_memory_port_val.ctl[`CTL_RD] = !((s_reg.state == external_memory_port_pkg::ST_STROBE) && !s_reg.write);
            external_memory_port_val.ctl[`CTL_WR] = !((s_reg.state == external_memory_port_pkg::ST_STROBE) && s_reg.write);
            claim.ad = '1;
            if (mux_mode) begin
                external_memory_port_val.ad = data_phase ? s_reg.wdata : s_reg.addr[7:0];
            end else begin
                claim.alo = '1;
                external_memory_port_val.alo = s_reg.addr[7:0];
                external_memory_port_val.ad = s_reg.wdata;
            end
            if (!s_reg.write && (!mux_mode || data_phase)) begin
                in_mask.ad = '1;
            end
            if (s_reg.drive_hi) begin
                claim.ahi = '1;
                external_memory_port_val.ahi = s_reg.addr[`RAM_ADDR_W-1:8];
            end
        end
        merged = (claim & external_memory_port_val) | (~claim & port_latch);
        s_next.claim = claim;
        s_next.pin_out = merged;
        s_next.pin_oe_n = in_mask | drive_enable_n(merged, port_pushpull);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.page <= `PAGE_RESET;
            s_reg.mode <= `MODE_RESET;
            s_reg.ale_w <= `ALE_RESET;
            s_reg.eas <= `SETUP_RESET;
            s_reg.ewr <= `STROBE_RESET;
            s_reg.eah <= `HOLD_RESET;
            s_reg.pin_out <= '1;
            s_reg.pin_oe_n <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign move_done = s_reg.done;
    assign move_rdata = s_reg.rdata;
    assign busy = s_reg.busy;
    assign pin_out = s_reg.pin_out;
    assign pin_oe_n = s_reg.pin_oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Length of each claim of the control pins
    logic [6:0] claim_len;
    logic [6:0] claim_expect;
    always_ff @(posedge clk) begin
        if (reset || !s_reg.claim.ctl[`CTL_RD]) begin
            claim_len <= 7'h00;
        end else begin
            claim_len <= claim_len + 7'h01;
        end
    end
    assign claim_expect = {5'h00, s_reg.eas} + {3'h0, s_reg.ewr} + 7'h01 + {5'h00, s_reg.eah} +
                          `ACCESS_OVERHEAD - 7'h01 + (mux_mode ? ({5'h00, s_reg.ale_w} + 7'h01) * 7'h02 : 7'h00);

    property p_one_strobe;
        @(posedge clk) disable iff (reset)
        s_reg.claim.ctl[`CTL_RD] |-> (s_reg.pin_out.ctl[`CTL_RD] || s_reg.pin_out.ctl[`CTL_WR]);
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");

    property p_access_len;
        @(posedge clk) disable iff (reset)
        $fell(s_reg.claim.ctl[`CTL_RD]) |-> (claim_len == $past(claim_expect));
    endproperty
    a_access_len: assert property (p_access_len) else $error("off-chip access length wrong");

    property p_internal_only;
        @(posedge clk) disable iff (reset)
        (s_reg.state == external_memory_port_pkg::ST_IDLE && move_valid && s_reg.mode == `MODE_INTERNAL) |=>
            (s_reg.claim == '0) [*3];
    endproperty
    a_internal_only: assert property (p_internal_only) else $error("internal mode claimed pins");

    property p_reset_timing;
        @(posedge clk)
        $past(reset) && !reset |-> (s_reg.eas == `SETUP_RESET && s_reg.eah == `HOLD_RESET);
    endproperty
    a_reset_timing: assert property (p_reset_timing) else $error("timing not at maximum after reset");

    property p_read_float;
        @(posedge clk) disable iff (reset)
        (s_reg.state == external_memory_port_pkg::ST_STROBE && !s_reg.write) |=> (s_reg.pin_oe_n.ad == 8'hFF);
    endproperty
    a_read_float: assert property (p_read_float) else $error("data pins driven during read");

    property p_upper_free;
        @(posedge clk) disable iff (reset)
        (s_reg.state == external_memory_port_pkg::ST_ADDR && !s_reg.is16 && s_reg.mode != `MODE_SPLIT_BANK) |=>
            (s_reg.claim.ahi == 4'h0);
    endproperty
    a_upper_free: assert property (p_upper_free) else $error("upper address claimed");

    property p_bank_hi;
        @(posedge clk) disable iff (reset)
        (s_reg.state == external_memory_port_pkg::ST_STROBE && s_reg.mode == `MODE_SPLIT_BANK && !s_reg.is16 && $stable(s_reg.page))
            |=> (s_reg.claim.ahi == 4'hF && s_reg.pin_out.ahi == s_reg.page[`PAGE_BANK_MSB:0]);
    endproperty
    a_bank_hi: assert property (p_bank_hi) else $error("bank bits not on upper address");

    property p_release;
        @(posedge clk) disable iff (reset)
        s_reg.done |-> (s_reg.claim == '0);
    endproperty
    a_release: assert property (p_release) else $error("pins held after move");

    property p_split_page;
        @(posedge clk) disable iff (reset)
        (s_reg.state == external_memory_port_pkg::ST_IDLE && move_valid && !move_req.is_16bit &&
         s_reg.mode == `MODE_SPLIT_NOBANK) |=> (s_reg.offchip == s_reg.page[`PAGE_OFFCHIP_BIT]);
    endproperty
    a_split_page: assert property (p_split_page) else $error("page bit misrouted move");

    property p_ale_short;
        @(posedge clk) disable iff (reset)
        ($rose(s_reg.pin_out.ctl[`CTL_ALE] && s_reg.claim.ctl[`CTL_ALE]) && s_reg.ale_w == 2'h0) |=>
            !s_reg.pin_out.ctl[`CTL_ALE] ##1 !s_reg.pin_out.ctl[`CTL_ALE];
    endproperty
    a_ale_short: assert property (p_ale_short) else $error("latch strobe width wrong");

endmodule

// >>> sim/ext_sram_model.sv
// Behavioural off-chip byte memory hanging on the external port pins
`timescale 1ns/1ns
`include "external_memory_port_cfg.svh"

module ext_sram_model (
    // Clock
    input wire logic clk,
    // Pins as seen on the board
    input wire external_memory_port_pkg::pin_vals_s pin_out,
    input wire logic mux_mode,
    input wire logic slow,
    // Value the memory puts on the shared data lines
    output logic [7:0] ad_drv
);
    logic [7:0] mem [0:4095];
    logic [7:0] lat_lo;
    logic [7:0] last = 8'h00;
    logic [1:0] rd_age = 2'h0;
    logic [11:0] addr;

    // Transparent address latch, open while the latch strobe is high
    always_latch begin
        if (pin_out.ctl[`CTL_ALE]) begin
            lat_lo = pin_out.ad;
        end
    end

    // Low address from the latch when the bus is shared
    assign addr = {pin_out.ahi, mux_mode ? lat_lo : pin_out.alo};

    // Write on every low cycle of the write strobe, count read-low cycles
    always @(posedge clk) begin
        if (!pin_out.ctl[`CTL_WR]) begin
            mem[addr] <= pin_out.ad;
        end
        rd_age <= pin_out.ctl[`CTL_RD] ? 2'h0 : (rd_age == 2'h3 ? 2'h3 : rd_age + 2'h1);
        last <= ad_drv;
    end

    // A slow part shows garbage in the first read cycle; released lines keep toggling
    assign ad_drv = (!pin_out.ctl[`CTL_RD] && (!slow || rd_age != 2'h0)) ? mem[addr] : ~last;
endmodule

// >>> sim/external_data_memory_interface_tb.sv
// Self-checking bench for the external data memory interface
`timescale 1ns/1ns

module external_data_memory_interface_tb;
    typedef struct packed {
        logic [1:0] mode;
        logic is16;
        logic wr;
        logic [4:0] page;
        logic [7:0] idx;
        logic [15:0] data_pointer_register;
        logic [7:0] d;
        logic off;
        logic [11:0] pa;
    } row_s;

    logic clk, reset, page_we, config_we, timing_we, mux_mode, move_valid, move_done, busy, slow;
    logic [7:0] reg_wdata, move_rdata, ad_in, ad_drv;
    logic [1:0] ale_set;
    logic mon, both_low, ahi_moved;
    external_memory_port_pkg::move_req_s move_req;
    external_memory_port_pkg::pin_vals_s pin_out, pin_oe_n, port_latch, port_pushpull;
    int n_mismatch, checks, rd_c, wr_c, ale_c, claim_c, lat, lat_base, s_set, w_set, h_set;
    row_s rows [0:10];

    external_memory_port_core i_dut (.clk(clk), .reset(reset), .page_we(page_we), .config_we(config_we),
        .timing_we(timing_we), .reg_wdata(reg_wdata), .mux_mode(mux_mode), .move_valid(move_valid),
        .move_req(move_req), .move_done(move_done), .move_rdata(move_rdata), .busy(busy),
        .ad_in(ad_in), .port_latch(port_latch), .port_pushpull(port_pushpull),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));

    ext_sram_model i_mem (.clk(clk), .pin_out(pin_out), .mux_mode(mux_mode), .slow(slow), .ad_drv(ad_drv));

    // Data wire: the driving party wins, released lines come from the memory
    assign ad_in = (pin_out.ad & ~pin_oe_n.ad) | (ad_drv & pin_oe_n.ad);

    // Clock
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    // Pin activity counters during a move
    always @(posedge clk) begin
        if (mon) begin
            rd_c += !pin_out.ctl[0];
            wr_c += !pin_out.ctl[1];
            ale_c += pin_out.ctl[2];
            claim_c += (pin_oe_n.ad == 8'hFF);
            if (!pin_out.ctl[0] && !pin_out.ctl[1]) both_low = 1'h1;
            if (pin_out.ahi !== 4'hA) ahi_moved = 1'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic chk(input logic [22:0] got, input logic [22:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One-cycle configuration strobe: 0 page, 1 config, 2 timing
    task automatic wreg(input int sel, input logic [7:0] v);
        @(negedge clk);
        reg_wdata = v;
        page_we = (sel == 0);
        config_we = (sel == 1);
        timing_we = (sel == 2);
        @(negedge clk);
        page_we = 1'h0;
        config_we = 1'h0;
        timing_we = 1'h0;
    endtask

    // Reset for 12 cycles, pins released meanwhile
    task automatic do_reset();
        @(negedge clk);
        reset = 1'h1;
        repeat (12) @(negedge clk);
        chk(pin_out, 23'h7FFFFF);
        chk(pin_oe_n, 23'h7FFFFF);
        chk({move_done, busy}, 0);
        reset = 1'h0;
        @(negedge clk);
        chk(pin_out, port_latch);
        $display("Reset test finished");
    endtask

    // One external move with all its pin checks
    task automatic move(input row_s r);
        wreg(1, {4'h0, r.mode, ale_set});
        wreg(0, {3'h0, r.page});
        @(negedge clk);
        move_req = '{r.is16, r.wr, r.idx, r.data_pointer_register, r.d};
        move_valid = 1'h1;
        {rd_c, wr_c, ale_c, claim_c, both_low, ahi_moved} = 0;
        mon = 1'h1;
        @(negedge clk);
        move_valid = 1'h0;
        chk(busy, 1'h1);
        lat = 0;
        while (move_done !== 1'h1) begin
            if (lat > 300) begin
                n_mismatch++;
                finish_test();
            end
            @(negedge clk);
            lat++;
        end
        mon = 1'h0;
        if (!r.off) chk(lat, 2);
        chk(r.wr ? wr_c : rd_c, r.off ? w_set : 0);
        chk(r.wr ? rd_c : wr_c, 0);
        chk(both_low, 0);
        if (!r.wr) chk(move_rdata, r.d);
        if (r.wr && r.off) chk(i_mem.mem[r.pa], r.d);
        if (!r.wr && r.off && !mux_mode) chk(claim_c, s_set + w_set + h_set + 3);
        if (r.off && !r.is16 && r.mode != 2'h2) chk(ahi_moved, 0);
        if (r.off && (r.is16 || r.mode == 2'h2) && r.pa[11:8] != 4'hA) chk(ahi_moved, 1);
        if (mux_mode) chk(ale_c, ale_set + 1);
        $display("Move test finished, latency %0d", lat);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {reset, page_we, config_we, timing_we, mux_mode, move_valid, slow, mon} = 8'h80;
        reg_wdata = 8'h00;
        move_req = '0;
        port_latch = '{8'hFF, 8'hFF, 4'hA, 3'h3};
        port_pushpull = '{8'hFF, 8'hFF, 4'h0, 3'h7};
        {n_mismatch, checks, lat_base} = 0;
        ale_set = 2'h0;
        {s_set, w_set, h_set} = {32'd0, 32'd1, 32'd0};
        rows[0] = '{2'h0, 1'h0, 1'h1, 5'h1F, 8'h34, 16'h0000, 8'h5A, 1'h0, 12'h000};
        rows[1] = '{2'h0, 1'h1, 1'h0, 5'h00, 8'h00, 16'hFF34, 8'h5A, 1'h0, 12'h000};
        rows[2] = '{2'h1, 1'h0, 1'h1, 5'h10, 8'h21, 16'h0000, 8'hC3, 1'h1, 12'hA21};
        rows[3] = '{2'h1, 1'h0, 1'h0, 5'h1A, 8'h21, 16'h0000, 8'hC3, 1'h1, 12'hA21};
        rows[4] = '{2'h1, 1'h1, 1'h1, 5'h00, 8'h00, 16'h1234, 8'h96, 1'h1, 12'h234};
        rows[5] = '{2'h2, 1'h0, 1'h1, 5'h12, 8'h34, 16'h0000, 8'h3C, 1'h1, 12'h234};
        rows[6] = '{2'h2, 1'h1, 1'h0, 5'h00, 8'h00, 16'h1234, 8'h3C, 1'h1, 12'h234};
        rows[7] = '{2'h2, 1'h1, 1'h1, 5'h00, 8'h00, 16'h0F34, 8'h77, 1'h0, 12'h000};
        rows[8] = '{2'h0, 1'h0, 1'h0, 5'h0F, 8'h34, 16'h0000, 8'h77, 1'h0, 12'h000};
        rows[9] = '{2'h3, 1'h0, 1'h1, 5'h05, 8'h34, 16'h0000, 8'hE1, 1'h1, 12'hA34};
        rows[10] = '{2'h3, 1'h1, 1'h0, 5'h00, 8'h00, 16'h0A34, 8'hE1, 1'h1, 12'hA34};
        do_reset();
        wreg(2, 8'h00);
        for (int i = 0; i <= 10; i++) begin
            move(rows[i]);
            if (i == 3) lat_base = lat;
        end
        // Longer programmed timing against a slow memory
        slow = 1'h1;
        {s_set, w_set, h_set} = {32'd2, 32'd4, 32'd1};
        wreg(2, 8'h8D);
        move(rows[3]);
        chk(lat, lat_base + 6);
        slow = 1'h0;
        // Shared bus with shortest and longest latch strobe
        mux_mode = 1'h1;
        {s_set, w_set, h_set} = {32'd0, 32'd1, 32'd0};
        wreg(2, 8'h00);
        for (int k = 0; k < 2; k++) begin
            ale_set = k ? 2'h3 : 2'h0;
            move(rows[9 + k]);
            chk(lat, lat_base + 2 * (ale_set + 1));
        end
        mux_mode = 1'h0;
        // Second reset brings back the longest timing
        do_reset();
        {s_set, w_set, h_set} = {32'd3, 32'd16, 32'd3};
        move(rows[10]);
        chk(lat, lat_base + 21);
        // Idle pins follow the latches and output modes
        chk(pin_out, port_latch);
        chk(pin_oe_n, ~port_pushpull & port_latch);
        $display("Idle pin test finished");
        finish_test();
    end
endmodule
